// file: dv/bus_peer_model.sv
// Model of another master on the two-wire bus that makes start and stop conditions.
`timescale 1ns/10ps
module bus_peer_model (
   // Bus lines, driven high by this model when released
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // start framing
   // SDA is raised while SCL is low, so no stop is made on the way in.
   task automatic send_start();
      sda = 1'b1;
      #50 scl = 1'b1;
      #50 sda = 1'b0;
      #50 scl = 1'b0;
      #50;
   endtask
   // stop framing
   // Only valid after a start, while SCL is still held low.
   task automatic send_stop();
      sda = 1'b0;
      #50 scl = 1'b1;
      #50 sda = 1'b1;
      #50;
   endtask
endmodule

// file: dv/i2c_bus_flag_register_test.sv
// Self-checking testbench of the bus flag and option register.
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin errors++; $display("CHECK FAILED %0t %s", $time, msg); end end
module i2c_bus_flag_register_test;
   import bus_flag_pkg::*;
   logic       clk_sys;
   logic       rst_n;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       scl;
   logic       sda;
   logic       start_blocked;
   logic       start_req_out;
   logic       start_allowed;
   logic       reserve_en;
   logic       irq;
   int         errors;
   int         tests_run;
   bus_flag_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl), .sda_in(sda),
      .start_blocked(start_blocked), .start_req_out(start_req_out), .start_allowed(start_allowed),
      .reserve_en(reserve_en), .irq(irq));
   bus_peer_model i_peer (.scl(scl), .sda(sda));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Register bus tasks
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Polls the busy flag; a bus condition takes a few cycles to pass the synchronisers.
   task automatic wait_busy(input logic val);
      logic [7:0] f;
      int         n;
      n = 0;
      rd(OFS_FLAGS, f);
      while (f[BIT_BUSY] !== val && n < 40) begin
         rd(OFS_FLAGS, f);
         n++;
      end
      if (f[BIT_BUSY] !== val) begin
         errors++;
         $display("CHECK FAILED %0t busy wait timed out", $time);
         final_report();
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_reset();
      logic [7:0] f;
      rd(OFS_FLAGS, f);
      `CHK(f, RST_FLAGS, "flags after reset")
      `CHK(reserve_en, 1'b1, "reservation after reset")
      rd(4'hF, f);
      `CHK(f, 8'h00, "unmapped read")
      $display("test_reset done");
   endtask
   task automatic test_options();
      logic [7:0] f;
      wr(OFS_FLAGS, 8'h03);
      rd(OFS_FLAGS, f);
      `CHK(f, 8'h03, "option byte write")
      `CHK(reserve_en, 1'b0, "reservation disabled")
      wr(OFS_FLAGS, 8'hC0);
      rd(OFS_FLAGS, f);
      `CHK(f, 8'h00, "read-only flags written")
      wr(OFS_BIT_WR, 8'h81);
      rd(OFS_FLAGS, f);
      `CHK(f, 8'h02, "single bit write")
      `CHK(reserve_en, 1'b1, "reservation enabled")
      $display("test_options done");
   endtask
   task automatic test_busy();
      logic [7:0] f;
      wr(OFS_FLAGS, 8'h00);
      wr(OFS_IRQ_EN, 8'h02);
      wr(OFS_CONTROL, 8'h01);
      rd(OFS_FLAGS, f);
      `CHK(f, 8'h40, "busy at enable without initial start")
      wr(OFS_FLAGS, 8'h03);
      rd(OFS_FLAGS, f);
      `CHK(f, 8'h40, "options locked while enabled")
      `CHK(start_allowed, 1'b0, "start held until stop")
      i_peer.send_start();
      i_peer.send_stop();
      wait_busy(1'b0);
      settle(2);
      `CHK(start_allowed, 1'b1, "start allowed after stop")
      wr(OFS_IRQ_CLR, 8'h07);
      i_peer.send_start();
      wait_busy(1'b1);
      settle(2);
      `CHK(irq, 1'b1, "interrupt on start")
      wr(OFS_IRQ_EN, 8'h00);
      settle(2);
      `CHK(irq, 1'b0, "interrupt masked")
      wr(OFS_IRQ_EN, 8'h02);
      wr(OFS_IRQ_CLR, 8'h02);
      settle(2);
      `CHK(irq, 1'b0, "interrupt cleared")
      $display("test_busy done");
   endtask
   task automatic test_init_start();
      logic [7:0] f;
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_FLAGS, 8'h02);
      wr(OFS_CONTROL, 8'h01);
      rd(OFS_FLAGS, f);
      `CHK(f, 8'h02, "bus free at enable with initial start")
      settle(1);
      `CHK(start_allowed, 1'b1, "start allowed without stop")
      i_peer.send_start();
      wait_busy(1'b1);
      rd(OFS_FLAGS, f);
      `CHK(f, 8'h40, "initial start cleared by start")
      i_peer.send_stop();
      $display("test_init_start done");
   endtask
   task automatic test_start_fail();
      logic [7:0] f;
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_FLAGS, 8'h01);
      wr(OFS_IRQ_CLR, 8'h07);
      start_blocked <= 1'b1;
      wr(OFS_CONTROL, 8'h03);
      settle(2);
      rd(OFS_FLAGS, f);
      `CHK(f, 8'hC1, "start failure flagged")
      `CHK(start_req_out, 1'b0, "request dropped")
      rd(OFS_IRQ_STAT, f);
      `CHK(f[IRQ_START_FAIL], 1'b1, "failure event status")
      start_blocked <= 1'b0;
      wr(OFS_CONTROL, 8'h03);
      settle(2);
      rd(OFS_FLAGS, f);
      `CHK(f, 8'h41, "failure cleared by new request")
      `CHK(start_req_out, 1'b1, "request kept")
      $display("test_start_fail done");
   endtask
   initial begin
      errors        = 0;
      tests_run     = 0;
      rst_n         = 1'b0;
      reg_addr      = 4'h0;
      reg_wdata     = 8'h00;
      reg_wr        = 1'b0;
      reg_rd        = 1'b0;
      start_blocked = 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      test_reset();
      test_options();
      test_busy();
      test_init_start();
      test_start_fail();
      final_report();
   end
endmodule

// file: include/bus_flag_pkg.sv
// Package with the register map, field positions and reset values of the bus flag block.
package bus_flag_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [3:0] OFS_FLAGS     = 4'h0;
   localparam logic [3:0] OFS_CONTROL   = 4'h1;
   localparam logic [3:0] OFS_IRQ_STAT  = 4'h2;
   localparam logic [3:0] OFS_IRQ_EN    = 4'h3;
   localparam logic [3:0] OFS_IRQ_CLR   = 4'h4;
   localparam logic [3:0] OFS_BIT_WR    = 4'h5;
   // ----------------------------------------
   // Field positions of bus_flag_options
   // ----------------------------------------
   localparam int BIT_RSV_DIS    = 0;
   localparam int BIT_INIT_START = 1;
   localparam int BIT_BUSY       = 6;
   localparam int BIT_START_FAIL = 7;
   // Control register fields.
   localparam int BIT_OP_EN      = 0;
   localparam int BIT_START_REQ  = 1;
   // Interrupt status fields.
   localparam int IRQ_START_FAIL = 0;
   localparam int IRQ_BUSY_SET   = 1;
   localparam int IRQ_BUSY_CLR   = 2;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_FLAGS   = 8'h00;
   localparam logic [1:0] RST_CONTROL = 2'h0;
   localparam logic [2:0] RST_IRQ     = 3'h0;
endpackage

// file: logic/bus_cond_detect.sv
// Start and stop condition detector for the two-wire bus lines.
`timescale 1ns/10ps
module bus_cond_detect (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Bus lines, already synchronised
   input  wire logic scl_s,
   input  wire logic sda_s,
   // Detected conditions, one-cycle pulses
   output logic      start_det,
   output logic      stop_det
);
   logic sda_prev_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sda_prev_q <= 1'b1;
      end else begin
         sda_prev_q <= sda_s;
      end
   end

   // A data edge while the clock line is high marks a condition.
   always_comb begin
      start_det = scl_s && sda_prev_q && !sda_s;
      stop_det  = scl_s && !sda_prev_q && sda_s;
   end
endmodule

// file: logic/bus_flag_regs.sv
// Flag and option register of a two-wire bus controller, with its interrupt logic.
// ----------------------------------------
// Function
// - The flag register is read as a whole byte and written as a whole byte or a single bit.
// - The start-failure and bus-busy flags are read-only and ignore writes.
// - The reservation-disable bit at 0 enables communication reservation and at 1 disables it.
// - The initial-start-enable bit sets the starting value of the busy flag when operation begins.
// - The two option bits are written only while controller operation is disabled.
// - With operation enabled the full flag register still reads back.
// - Reset clears every bit of the flag register.
// - Start-failure sets when a start cannot be made with reservation disabled and clears on a new request.
// ----------------------------------------
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
module bus_flag_regs
   import bus_flag_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Bus lines
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   // Start generator handshake
   input  wire logic       start_blocked,
   output logic            start_req_out,
   output logic            start_allowed,
   output logic            reserve_en,
   // Interrupt
   output logic            irq
);
   // ----------------------------------------
   // Synchronisers and condition detection
   // ----------------------------------------
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic       start_det;
   logic       stop_det;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
      end
   end

   bus_cond_detect u_detect (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .scl_s     (scl_sync_q[1]),
      .sda_s     (sda_sync_q[1]),
      .start_det (start_det),
      .stop_det  (stop_det)
   );

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   // Byte writes go to OFS_FLAGS; single-bit writes go to OFS_BIT_WR with
   // the bit index in wdata[2:0] and the value in wdata[7].
   function automatic logic [7:0] merge_write(input logic [3:0] addr, input logic [7:0] wd,
                                              input logic [7:0] cur);
      logic [7:0] r;
      r = cur;
      if (addr == OFS_FLAGS) begin
         r = wd;
      end else if (addr == OFS_BIT_WR) begin
         r[wd[2:0]] = wd[7];
      end
      return r;
   endfunction

   logic [7:0] flags_q;
   logic [7:0] wr_val;
   logic       flag_wr;
   logic       op_en_q;
   logic       start_req_q;
   logic       op_en_rise;

   always_comb begin
      flag_wr = reg_wr && (reg_addr == OFS_FLAGS || reg_addr == OFS_BIT_WR);
      wr_val  = merge_write(reg_addr, reg_wdata, flags_q);
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic op_en_prev_q;
   logic fail_evt;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         op_en_q      <= RST_CONTROL[BIT_OP_EN];
         op_en_prev_q <= 1'b0;
      end else begin
         op_en_prev_q <= op_en_q;
         if (reg_wr && reg_addr == OFS_CONTROL) begin
            op_en_q <= reg_wdata[BIT_OP_EN];
         end
      end
   end

   assign op_en_rise = op_en_q && !op_en_prev_q;
   assign fail_evt   = start_req_q && start_blocked && flags_q[BIT_RSV_DIS];

   // Start request is cleared by hardware when the start cannot be made with reservation disabled.
   // The failure wins over a request written in the same cycle, so the
   // request bit and the failure flag never disagree.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         start_req_q <= RST_CONTROL[BIT_START_REQ];
      end else if (fail_evt) begin
         start_req_q <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_CONTROL) begin
         start_req_q <= reg_wdata[BIT_START_REQ] && reg_wdata[BIT_OP_EN];
      end else if (start_det || !op_en_q) begin
         start_req_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Flag register
   // ----------------------------------------
   logic new_req;
   assign new_req = reg_wr && reg_addr == OFS_CONTROL && reg_wdata[BIT_START_REQ];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= RST_FLAGS;
      end else begin
         if (flag_wr && !op_en_q) begin
            flags_q[BIT_RSV_DIS] <= wr_val[BIT_RSV_DIS];
         end
         if (start_det) begin
            flags_q[BIT_INIT_START] <= 1'b0;
         end else if (flag_wr && !op_en_q) begin
            flags_q[BIT_INIT_START] <= wr_val[BIT_INIT_START];
         end
         if (fail_evt) begin
            flags_q[BIT_START_FAIL] <= 1'b1;
         end else if (new_req) begin
            flags_q[BIT_START_FAIL] <= 1'b0;
         end
         // busy on start, free on stop
         if (start_det) begin
            flags_q[BIT_BUSY] <= 1'b1;
         end else if (stop_det) begin
            flags_q[BIT_BUSY] <= 1'b0;
         end else if (op_en_rise) begin
            // starting busy value; set means wait for a stop first
            flags_q[BIT_BUSY] <= !flags_q[BIT_INIT_START];
         end
         // read-only flags are never loaded from wr_val.
      end
   end

   // ----------------------------------------
   // Start gate and outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         start_req_out <= 1'b0;
         start_allowed <= 1'b0;
         reserve_en    <= 1'b1;
      end else begin
         start_req_out <= start_req_q;
         start_allowed <= op_en_q && (flags_q[BIT_INIT_START] || !flags_q[BIT_BUSY]);
         reserve_en    <= !flags_q[BIT_RSV_DIS];
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   logic [2:0] irq_stat_q;
   logic [2:0] irq_en_q;
   logic [2:0] irq_evt;
   logic [2:0] irq_clr;

   assign irq_evt = {stop_det, start_det, fail_evt};
   assign irq_clr = (reg_wr && reg_addr == OFS_IRQ_CLR) ? reg_wdata[2:0] : 3'h0;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= RST_IRQ;
         irq_en_q   <= RST_IRQ;
         irq        <= 1'b0;
      end else begin
         // A new event beats a clear in the same cycle.
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
         if (reg_wr && reg_addr == OFS_IRQ_EN) begin
            irq_en_q <= reg_wdata[2:0];
         end
         irq <= |(((irq_stat_q & ~irq_clr) | irq_evt) & irq_en_q);
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            OFS_FLAGS:    reg_rdata <= flags_q;
            OFS_CONTROL:  reg_rdata <= {6'h00, start_req_q, op_en_q};
            OFS_IRQ_STAT: reg_rdata <= {5'h00, irq_stat_q};
            OFS_IRQ_EN:   reg_rdata <= {5'h00, irq_en_q};
            default:      reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_ro_flags_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (flag_wr && !fail_evt && !new_req && !start_det && !stop_det && !op_en_rise)
      |=> (flags_q[7:6] == $past(flags_q[7:6])))
      else $error("read-only flags changed by write");
   a_opt_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (flag_wr && op_en_q && !start_det) |=> $stable(flags_q[1:0]))
      else $error("option bits written while enabled");
   a_opt_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_FLAGS && !op_en_q && !start_det) |=> flags_q[1:0] == $past(reg_wdata[1:0]))
      else $error("option byte write lost");
   a_fail_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fail_evt |=> flags_q[BIT_START_FAIL] && !start_req_q)
      else $error("start failure not flagged");
   a_fail_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (new_req && !fail_evt) |=> !flags_q[BIT_START_FAIL])
      else $error("start failure not cleared by request");
   a_busy_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
      start_det |=> flags_q[BIT_BUSY] && !flags_q[BIT_INIT_START])
      else $error("busy not set on start");
   a_busy_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (stop_det && !start_det) |=> !flags_q[BIT_BUSY])
      else $error("busy not cleared on stop");
   a_busy_init: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_en_rise && !start_det && !stop_det) |=> flags_q[BIT_BUSY] == !$past(flags_q[BIT_INIT_START]))
      else $error("busy start value wrong");
   a_reserve_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> reserve_en == !$past(flags_q[BIT_RSV_DIS]))
      else $error("reservation output wrong");
   a_read_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_rd && reg_addr == OFS_FLAGS) |=> reg_rdata == $past(flags_q))
      else $error("flag readback wrong");
   // Each hold check names every cause that may move its bit, so a stray path is caught.
   a_gate_open: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_en_q && !flags_q[BIT_BUSY]) |=> start_allowed)
      else $error("start gate closed on a free bus");
   a_gate_init: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_en_q && flags_q[BIT_INIT_START]) |=> start_allowed)
      else $error("start gate closed with initial start");
   a_gate_shut: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!op_en_q || (flags_q[BIT_BUSY] && !flags_q[BIT_INIT_START])) |=> !start_allowed)
      else $error("start gate open on a busy bus");
   a_req_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fail_evt |=> ##1 !start_req_out)
      else $error("request output kept after failure");
   a_bit_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_BIT_WR && reg_wdata[2:0] == 3'h1 && !op_en_q && !start_det)
      |=> flags_q[BIT_INIT_START] == $past(reg_wdata[7]))
      else $error("single bit write lost");
   a_rsv_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      op_en_q |=> $stable(flags_q[BIT_RSV_DIS]))
      else $error("reservation bit changed while enabled");
   a_busy_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!start_det && !stop_det && !op_en_rise) |=> $stable(flags_q[BIT_BUSY]))
      else $error("busy flag moved without a bus condition");
   a_fail_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!fail_evt && !new_req) |=> $stable(flags_q[BIT_START_FAIL]))
      else $error("start failure flag moved without cause");

   // ----------------------------------------
   // Cover points
   // ----------------------------------------
   c_fail: cover property (@(posedge clk_sys) fail_evt);
   c_busy_cycle: cover property (@(posedge clk_sys) start_det ##[1:50] stop_det);
   c_irq: cover property (@(posedge clk_sys) $rose(irq));
   c_init_start: cover property (@(posedge clk_sys) op_en_rise && flags_q[BIT_INIT_START]);
   c_opt_locked: cover property (@(posedge clk_sys) flag_wr && op_en_q);
endmodule
